/* abd_datapath.sv */
// Execution datapath for add, AND, bit clear/set and bit test-and-skip.
// Assumes the decoder presents one instruction per instr_valid pulse, with
// the addressed register's contents on rf_rdata in the same cycle.
`timescale 1ns/1ps
`include "abd_cfg.svh"

// Operation
// (RULE1) add_literal_to_accumulator: accumulator plus literal into accumulator, three flags updated
// (RULE2) add_register_op: accumulator plus addressed register, three flags updated from sum
// (RULE3) Destination bit zero writes accumulator, one writes back addressed register
// (RULE4) and_literal_op: accumulator AND literal into accumulator, only null flag
// (RULE5) and_register_op: accumulator AND register to chosen destination, only null flag
// (RULE6) clear_register_bit: selected register bit forced to zero, flags unchanged
// (RULE7) set_register_bit: selected register bit forced to one, flags unchanged
// (RULE8) test_bit_skip_if_zero: bit zero discards next instruction, runs NOP instead
// (RULE9) test_bit_skip_if_one: bit one discards next instruction, runs NOP instead
// (RULE10) Successful conditional test takes two cycles, second one is a NOP
// (RULE11) Operands from I/O port registers use synchronised pin levels, not latches
// (RULE12) Null flag on zero result, carries from bit 7 and bit 3
// (RULE13) Every non-skipping instruction completes in one instruction cycle
module abd_datapath (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      instr_valid,
  input  wire abd_pkg::abd_op_t          instr_op,
  input  wire logic [`ABD_DATA_W-1:0]    instr_literal,
  input  wire logic [`ABD_ADDR_W-1:0]    instr_addr,
  input  wire logic                      instr_dest,
  input  wire logic [`ABD_BSEL_W-1:0]    instr_bit,
  input  wire logic [`ABD_DATA_W-1:0]    rf_rdata,
  input  wire logic                      port_is_io,
  input  wire logic [`ABD_DATA_W-1:0]    port_pins,
  output logic [`ABD_DATA_W-1:0]         accumulator_r,
  output logic                           byte_overflow_flag_r,
  output logic                           nibble_overflow_flag_r,
  output logic                           result_null_flag_r,
  output logic                           rf_we_r,
  output logic [`ABD_ADDR_W-1:0]         rf_waddr_r,
  output logic [`ABD_DATA_W-1:0]         rf_wdata_r,
  output logic                           skip_nop_r,
  output logic                           done_r
);

  // ****************************************
  // Functions
  // ****************************************
  // Returns {carry from bit 7, carry from bit 3, sum}
  function automatic logic [`ABD_DATA_W+1:0] abd_add(
    input logic [`ABD_DATA_W-1:0] a,
    input logic [`ABD_DATA_W-1:0] b
  );
    logic [`ABD_DATA_W:0]   full;
    logic [`ABD_NIB_MSB+1:0] low;
    full = {1'b0, a} + {1'b0, b};
    low  = {1'b0, a[`ABD_NIB_MSB:0]} + {1'b0, b[`ABD_NIB_MSB:0]};
    return {full[`ABD_DATA_W], low[`ABD_NIB_MSB+1], full[`ABD_DATA_W-1:0]};
  endfunction : abd_add

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [`ABD_DATA_W-1:0] pin_s1_r;
  logic [`ABD_DATA_W-1:0] pin_s2_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end
    else
    begin
      pin_s1_r <= port_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************
  // Operand and result
  // ****************************************
  abd_pkg::abd_state_t       state_r;
  logic                      exec;
  logic [`ABD_DATA_W-1:0]    opnd;
  logic [`ABD_DATA_W-1:0]    src_b;
  logic [`ABD_DATA_W+1:0]    sum;
  logic [`ABD_DATA_W-1:0]    res;
  logic                      bit_val;
  logic                      is_add;
  logic                      is_and;
  logic                      to_reg;
  logic                      skip_nxt;

  assign exec = instr_valid && (state_r == abd_pkg::ABD_ST_EXEC);

  // (RULE11) pin levels
  assign opnd    = port_is_io ? pin_s2_r : rf_rdata;
  assign src_b   = (instr_op == abd_pkg::ABD_OP_ADDL || instr_op == abd_pkg::ABD_OP_ANDL)
                   ? instr_literal : opnd;
  assign sum     = abd_add(accumulator_r, src_b);
  assign bit_val = opnd[instr_bit];
  assign is_add  = (instr_op == abd_pkg::ABD_OP_ADDL) || (instr_op == abd_pkg::ABD_OP_ADDR);
  assign is_and  = (instr_op == abd_pkg::ABD_OP_ANDL) || (instr_op == abd_pkg::ABD_OP_ANDR);

  always_comb
  begin
    res      = opnd;
    to_reg   = 1'b0;
    skip_nxt = 1'b0;
    unique case (instr_op)
      abd_pkg::ABD_OP_ADDL: res = sum[`ABD_DATA_W-1:0];
      abd_pkg::ABD_OP_ADDR:
      begin
        res    = sum[`ABD_DATA_W-1:0];
        to_reg = (instr_dest == `ABD_DEST_REG);
      end
      abd_pkg::ABD_OP_ANDL: res = accumulator_r & src_b;
      abd_pkg::ABD_OP_ANDR:
      begin
        res    = accumulator_r & src_b;
        to_reg = (instr_dest == `ABD_DEST_REG);
      end
      // (RULE6) bit clear
      abd_pkg::ABD_OP_BCLR:
      begin
        res            = opnd;
        res[instr_bit] = 1'b0;
        to_reg         = 1'b1;
      end
      // (RULE7) bit set
      abd_pkg::ABD_OP_BSET:
      begin
        res            = opnd;
        res[instr_bit] = 1'b1;
        to_reg         = 1'b1;
      end
      // (RULE8) skip on zero
      abd_pkg::ABD_OP_TSTZ: skip_nxt = ~bit_val;
      // (RULE9) skip on one
      abd_pkg::ABD_OP_TSTO: skip_nxt = bit_val;
      abd_pkg::ABD_OP_NOP:  res = opnd;
      default:              res = opnd;
    endcase
  end

  // ****************************************
  // Skip sequencing
  // ****************************************
  // (RULE10) second cycle as NOP
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= abd_pkg::ABD_ST_EXEC;
    else if (instr_valid && state_r == abd_pkg::ABD_ST_SKIP)
      state_r <= abd_pkg::ABD_ST_EXEC;
    else if (exec && skip_nxt)
      state_r <= abd_pkg::ABD_ST_SKIP;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      skip_nop_r <= 1'b0;
    else
      skip_nop_r <= instr_valid && (state_r == abd_pkg::ABD_ST_SKIP);
  end

  // (RULE13) one-cycle completion
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else
      done_r <= exec && !skip_nxt;
  end

  // ****************************************
  // Accumulator and register write-back
  // ****************************************
  // (RULE3) destination routing
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      accumulator_r <= `ABD_ACC_RST;
    else if (exec && (is_add || is_and) && !to_reg)
      accumulator_r <= res;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_we_r    <= 1'b0;
      rf_waddr_r <= 7'h00;
      rf_wdata_r <= 8'h00;
    end
    else
    begin
      rf_we_r <= exec && to_reg;
      if (exec && to_reg)
      begin
        rf_waddr_r <= instr_addr;
        rf_wdata_r <= res;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // (RULE12) flag sources
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_overflow_flag_r   <= `ABD_FLAG_RST;
      nibble_overflow_flag_r <= `ABD_FLAG_RST;
      result_null_flag_r     <= `ABD_FLAG_RST;
    end
    else if (exec && (is_add || is_and))
    begin
      result_null_flag_r <= (res == 8'h00);
      if (is_add)
      begin
        byte_overflow_flag_r   <= sum[`ABD_DATA_W+1];
        nibble_overflow_flag_r <= sum[`ABD_DATA_W];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_add_lit_acc: assert property ( // (RULE1)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_ADDL |=>
    accumulator_r == 8'($past(accumulator_r) + $past(instr_literal)))
    else $error("literal add result wrong");

  a_add_reg_flags: assert property ( // (RULE2)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_ADDR && !port_is_io |=>
    byte_overflow_flag_r == (9'({1'b0, $past(accumulator_r)}) + 9'({1'b0, $past(rf_rdata)}) > 9'h0FF))
    else $error("register add carry wrong");

  a_dest_route: assert property ( // (RULE3)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_ANDR && instr_dest == `ABD_DEST_REG |=>
    rf_we_r && accumulator_r == $past(accumulator_r))
    else $error("register destination not honoured");

  a_and_lit_flags: assert property ( // (RULE4)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_ANDL |=>
    $stable(byte_overflow_flag_r) && $stable(nibble_overflow_flag_r) &&
    accumulator_r == ($past(accumulator_r) & $past(instr_literal)))
    else $error("literal AND wrong");

  a_and_reg_null: assert property ( // (RULE5)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_ANDR && !port_is_io |=>
    result_null_flag_r == (($past(accumulator_r) & $past(rf_rdata)) == 8'h00))
    else $error("register AND null flag wrong");

  a_bit_clear: assert property ( // (RULE6)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_BCLR |=>
    rf_we_r && !rf_wdata_r[$past(instr_bit)] && $stable(result_null_flag_r))
    else $error("bit clear wrong");

  a_bit_set: assert property ( // (RULE7)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_BSET |=>
    rf_we_r && rf_wdata_r[$past(instr_bit)] && $stable(byte_overflow_flag_r))
    else $error("bit set wrong");

  a_skip_zero: assert property ( // (RULE8)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_TSTZ && !bit_val |=>
    state_r == abd_pkg::ABD_ST_SKIP && !done_r && !rf_we_r)
    else $error("skip on zero did not discard");

  a_skip_slot: assert property ( // (RULE10)
    @(posedge mclk) disable iff (!rst_n)
    instr_valid && state_r == abd_pkg::ABD_ST_SKIP |=>
    skip_nop_r && !done_r && !rf_we_r && $stable(accumulator_r))
    else $error("discarded slot not run as no-op");

  a_skip_one: assert property ( // (RULE9)
    @(posedge mclk) disable iff (!rst_n)
    exec && instr_op == abd_pkg::ABD_OP_TSTO && !bit_val |=>
    done_r && state_r == abd_pkg::ABD_ST_EXEC)
    else $error("skip on one misfired");

  a_io_operand: assert property ( // (RULE11)
    @(posedge mclk) disable iff (!rst_n)
    exec && port_is_io && instr_op == abd_pkg::ABD_OP_BSET |=>
    rf_wdata_r == ($past(pin_s2_r) | (8'h01 << $past(instr_bit))))
    else $error("port operand not taken from pins");

endmodule : abd_datapath

/* abd_cfg.svh */
// Constants for the add / AND / bit-operation datapath.
// Assumes inclusion by bare name from the package and the datapath.
`ifndef ABD_CFG_SVH
`define ABD_CFG_SVH

`define ABD_DATA_W      8
`define ABD_ADDR_W      7
`define ABD_BSEL_W      3
`define ABD_ACC_RST     8'h00
`define ABD_FLAG_RST    1'b0
`define ABD_NIB_MSB     3
`define ABD_DEST_ACC    1'b0
`define ABD_DEST_REG    1'b1

`endif

/* abd_pkg.sv */
// Types for the add / AND / bit-operation datapath.
// Assumes abd_cfg.svh is on the include path.
`include "abd_cfg.svh"

package abd_pkg;

  typedef enum logic [3:0] {
    ABD_OP_NOP   = 4'h0,
    ABD_OP_ADDL  = 4'h1,
    ABD_OP_ADDR  = 4'h2,
    ABD_OP_ANDL  = 4'h3,
    ABD_OP_ANDR  = 4'h4,
    ABD_OP_BCLR  = 4'h5,
    ABD_OP_BSET  = 4'h6,
    ABD_OP_TSTZ  = 4'h7,
    ABD_OP_TSTO  = 4'h8
  } abd_op_t;

  typedef enum logic {
    ABD_ST_EXEC = 1'b0,
    ABD_ST_SKIP = 1'b1
  } abd_state_t;

endpackage : abd_pkg

/* add_and_bit_ops_datapath_bench.sv */
// Self-checking bench for the add / AND / bit-operation datapath.
// Assumes abd_pkg.sv is compiled first and abd_cfg.svh is on the include path.
`timescale 1ns/1ps
`include "abd_cfg.svh"

module add_and_bit_ops_datapath_bench;
  logic             mclk          = 1'b0;
  logic             rst_n         = 1'b0;
  logic             instr_valid   = 1'b0;
  abd_pkg::abd_op_t instr_op      = abd_pkg::ABD_OP_NOP;
  logic [7:0]       instr_literal = 8'h00;
  logic [6:0]       instr_addr    = 7'h00;
  logic             instr_dest    = 1'b0;
  logic [2:0]       instr_bit     = 3'h0;
  logic [7:0]       rf_rdata      = 8'h00;
  logic             port_is_io    = 1'b0;
  logic [7:0]       port_pins     = 8'h00;
  logic [7:0]       acc;
  logic             c_f;
  logic             dc_f;
  logic             z_f;
  logic             we;
  logic [6:0]       waddr;
  logic [7:0]       wdata;
  logic             skip;
  logic             done;
  int               n_mismatch    = 0;
  int               num_checks    = 0;
  int               cycles        = 0;

  abd_datapath dut_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_literal(instr_literal), .instr_addr(instr_addr),
    .instr_dest(instr_dest), .instr_bit(instr_bit), .rf_rdata(rf_rdata),
    .port_is_io(port_is_io), .port_pins(port_pins), .accumulator_r(acc),
    .byte_overflow_flag_r(c_f), .nibble_overflow_flag_r(dc_f),
    .result_null_flag_r(z_f), .rf_we_r(we), .rf_waddr_r(waddr),
    .rf_wdata_r(wdata), .skip_nop_r(skip), .done_r(done));

  always #5 mclk = ~mclk;

  // ****************************************
  // Compare and drive helpers
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Flags packed as {byte carry, nibble carry, null}; ds is {done, skip}
  task automatic look(input logic [7:0] a, input logic [2:0] f, input logic w,
                      input logic [7:0] wd, input logic [1:0] ds);
    chk("accumulator", a, acc);
    chk("flags", {5'h00, f}, {5'h00, c_f, dc_f, z_f});
    chk("write_strobe", {7'h00, w}, {7'h00, we});
    if (w)
    begin
      chk("write_data", wd, wdata);
      chk("write_addr", {1'b0, instr_addr}, {1'b0, waddr});
    end
    chk("done_skip", {6'h00, ds}, {6'h00, done, skip});
  endtask : look

  // The literal also supplies the register address, so addresses vary per call
  task automatic run(input abd_pkg::abd_op_t op, input logic [7:0] k, input logic d,
                     input logic [2:0] b, input logic [7:0] rd);
    @(posedge mclk);
    instr_valid   <= 1'b1;
    instr_op      <= op;
    instr_literal <= k;
    instr_addr    <= k[6:0];
    instr_dest    <= d;
    instr_bit     <= b;
    rf_rdata      <= rd;
    @(posedge mclk);
    instr_valid   <= 1'b0;
    #1;
  endtask : run

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_add();
    run(abd_pkg::ABD_OP_ADDL, 8'h0F, 1'b0, 3'h0, 8'h00);
    look(8'h0F, 3'b000, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ADDL, 8'h01, 1'b0, 3'h0, 8'h00);
    look(8'h10, 3'b010, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ADDL, 8'hF0, 1'b0, 3'h0, 8'h00);
    look(8'h00, 3'b101, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ADDR, 8'h7F, 1'b0, 3'h0, 8'h55);
    look(8'h55, 3'b000, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ADDR, 8'h00, 1'b1, 3'h0, 8'hAB);
    look(8'h55, 3'b111, 1'b1, 8'h00, 2'b10);
    $display("test add finished");
  endtask : t_add

  task automatic t_and();
    run(abd_pkg::ABD_OP_ANDL, 8'h0F, 1'b0, 3'h0, 8'h00);
    look(8'h05, 3'b110, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ANDR, 8'h2A, 1'b1, 3'h0, 8'hF0);
    look(8'h05, 3'b111, 1'b1, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ANDR, 8'h15, 1'b0, 3'h0, 8'hFF);
    look(8'h05, 3'b110, 1'b0, 8'h00, 2'b10);
    $display("test and finished");
  endtask : t_and

  task automatic t_bits();
    for (int b = 0; b < 8; b++)
    begin
      run(abd_pkg::ABD_OP_BCLR, 8'h40 + 8'(b), 1'b0, 3'(b), 8'hFF);
      look(8'h05, 3'b110, 1'b1, 8'hFF ^ (8'h01 << b), 2'b10);
      run(abd_pkg::ABD_OP_BSET, 8'h20 + 8'(b), 1'b1, 3'(b), 8'h00);
      look(8'h05, 3'b110, 1'b1, 8'h01 << b, 2'b10);
    end
    $display("test bits finished");
  endtask : t_bits

  task automatic t_skip();
    run(abd_pkg::ABD_OP_TSTZ, 8'h03, 1'b0, 3'h3, 8'hF7);
    look(8'h05, 3'b110, 1'b0, 8'h00, 2'b00);
    run(abd_pkg::ABD_OP_ADDL, 8'h11, 1'b0, 3'h0, 8'h00);
    look(8'h05, 3'b110, 1'b0, 8'h00, 2'b01);
    run(abd_pkg::ABD_OP_TSTZ, 8'h03, 1'b0, 3'h3, 8'h08);
    look(8'h05, 3'b110, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ADDL, 8'h11, 1'b0, 3'h0, 8'h00);
    look(8'h16, 3'b000, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_TSTO, 8'h07, 1'b0, 3'h7, 8'h80);
    look(8'h16, 3'b000, 1'b0, 8'h00, 2'b00);
    run(abd_pkg::ABD_OP_ANDL, 8'h00, 1'b0, 3'h0, 8'h00);
    look(8'h16, 3'b000, 1'b0, 8'h00, 2'b01);
    run(abd_pkg::ABD_OP_TSTO, 8'h00, 1'b0, 3'h0, 8'hFE);
    look(8'h16, 3'b000, 1'b0, 8'h00, 2'b10);
    run(abd_pkg::ABD_OP_ANDL, 8'h00, 1'b0, 3'h0, 8'h00);
    look(8'h00, 3'b001, 1'b0, 8'h00, 2'b10);
    $display("test skip finished");
  endtask : t_skip

  // Operand must come from pin levels, not the register contents
  task automatic t_port();
    @(posedge mclk);
    port_is_io <= 1'b1;
    port_pins  <= 8'h3C;
    repeat (3) @(posedge mclk);
    run(abd_pkg::ABD_OP_BSET, 8'h11, 1'b1, 3'h0, 8'hFF);
    look(8'h00, 3'b001, 1'b1, 8'h3D, 2'b10);
    @(posedge mclk);
    port_is_io <= 1'b0;
    $display("test port finished");
  endtask : t_port

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    look(8'h00, 3'b000, 1'b0, 8'h00, 2'b00);
    t_add();
    t_and();
    t_bits();
    t_skip();
    t_port();
    test_done();
  end
endmodule : add_and_bit_ops_datapath_bench
